// ### src/tsp_fifo_top.v
// ============================================================
// tdm symbol port: slot state machine, demux and channel fifos
// assumes port clock, marker, data and qualifiers are asynchronous
// and slow (port clock well below a quarter of SYS_CLK_I)
// Function
// RULE_01 - one port clock and one marker shared by all ports; edges make slots
// RULE_02 - upstream pulses the marker one clock every N clocks, N 2 to 32
// RULE_03 - each channel holds port and slot entry; routing follows it
// RULE_04 - every port has 10-bit data, qualifier input and accept output
// RULE_05 - words are 6, 8, 10 or 12 bits depending on mapping mode; the code forms 10-bit or 12-bit words only
// RULE_06 - one shared offset applies to both i and q in 12-bit mode
// RULE_07 - bypass words carry q in upper half, i in lower half
// RULE_08 - a word is written only while its qualifier is high
// RULE_09 - each channel has a 16-word fifo toward the symbol side
// RULE_10 - accept output during own slot, low once fifo holds 8 or more
// RULE_11 - writes continue with qualifier high even while accept is low
// RULE_12 - overflow sets channel bit in overflow flags, cleared by read
// RULE_13 - underflow on read of empty fifo drives interrupt low if enabled
// RULE_14 - underflow sets channel bit in underflow flags, cleared by read
// RULE_15 - after underflow reading stays stopped until fifo refills to eight
// RULE_16 - no underflow until fifo reached half-full and transfer began
// RULE_17 - each port carries 2 to 32 streams, 128 in total
// RULE_18 - a single stream uses slot count 2 with one slot used
// RULE_19 - words in slots with no assigned channel are ignored
// RULE_20 - upstream port clock must cover slots times top symbol rate
// RULE_21 - sdr samples rising port clock edges; ddr samples both edges
// RULE_22 - all used ports share the same slot count
// RULE_23 - ddr: marker rising edge word is slot 1, next falling is slot 2
// RULE_24 - slot count even 2 to 32 in ddr, 2 to 16 in sdr
// RULE_25 - slot counter runs free after one marker; restarts on rollover or marker
// RULE_26 - channel on slot 0 is muted: no data, no handshake
// RULE_27 - write into a full fifo is dropped and flags overflow
`timescale 1ns/1ns
`include "tsp_fifo_consts.vh"
`default_nettype none

// ============================================================
// two-entry buffer, valid and ready on both sides
module tsp_buf2 #(
  parameter W = 12
) (
  input wire clk_i,
  input wire rst_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg v0_reg;
  reg v1_reg;
  reg [W-1:0] e0_reg;
  reg [W-1:0] e1_reg;
  wire push;
  wire pop;

  // ready comes straight from the second slot flag, no combinational path
  assign in_ready_o = ~v1_reg;
  assign out_valid_o = v0_reg;
  assign out_data_o = e0_reg;
  assign push = in_valid_i & ~v1_reg;
  assign pop = v0_reg & out_ready_i;

  // head in e0, tail in e1
  always @(posedge clk_i) begin
    if (rst_i) begin
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
      e0_reg <= {W{1'b0}};
      e1_reg <= {W{1'b0}};
    end else if (push && pop) begin
      if (v1_reg) begin
        e0_reg <= e1_reg;
        e1_reg <= in_data_i;
      end else begin
        e0_reg <= in_data_i;
      end
    end else if (pop) begin
      e0_reg <= e1_reg;
      v0_reg <= v1_reg;
      v1_reg <= 1'b0;
    end else if (push) begin
      if (v0_reg) begin
        e1_reg <= in_data_i;
        v1_reg <= 1'b1;
      end else begin
        e0_reg <= in_data_i;
        v0_reg <= 1'b1;
      end
    end
  end
endmodule // tsp_buf2

// ============================================================
// top: port sampling, slot tagging, demux, fifos, flags
module tsp_fifo_top #(
  parameter NCH = 128
) (
  // clock and reset
  input wire SYS_CLK_I,
  input wire SYS_RST_I,
  // symbol ports
  input wire PORT_CLK_I,
  input wire SLOT_MARK_I,
  input wire [`TSP_NPORT*`TSP_DW-1:0] PORT_DATA_I,
  input wire [`TSP_NPORT-1:0] WORD_QUAL_I,
  output reg [`TSP_NPORT-1:0] FIFO_ACCEPT_O,
  // port configuration
  input wire DDR_MODE_I,
  input wire [`TSP_SW-1:0] SLOT_COUNT_I,
  output reg CFG_ERR_O,
  // channel configuration
  input wire [NCH*`TSP_PW-1:0] CH_PORT_I,
  input wire [NCH*`TSP_SW-1:0] CH_SLOT_I,
  input wire [NCH-1:0] CH_OFS_EN_I,
  input wire [NCH-1:0] CH_OFS_I,
  // resampler read side
  output wire [NCH-1:0] RD_VALID_O,
  input wire [NCH-1:0] RD_READY_I,
  output wire [NCH*`TSP_OW-1:0] RD_DATA_O,
  // error flags
  output reg [NCH-1:0] OVF_FLAGS_O,
  input wire OVF_READ_I,
  output reg [NCH-1:0] UDF_FLAGS_O,
  input wire UDF_READ_I,
  input wire [NCH-1:0] UDF_IRQ_EN_I,
  output reg IRQ_N_O
);
  localparam NIN = `TSP_NPORT*`TSP_DW+`TSP_NPORT+2;

  reg [NIN-1:0] sync1_reg;
  reg [NIN-1:0] sync2_reg;
  reg clk_d_reg;
  reg [`TSP_SW-1:0] slot_reg;
  reg [`TSP_SW-1:0] slot_next;
  reg [`TSP_NPORT-1:0] accept_next;
  wire clk_s;
  wire mark_s;
  wire [`TSP_NPORT*`TSP_DW-1:0] data_s;
  wire [`TSP_NPORT-1:0] qual_s;
  wire rise;
  wire fall;
  wire edge_act;
  wire cfg_ok;
  wire [NCH*`TSP_NPORT-1:0] acc_vote;
  wire [NCH-1:0] ovf_ev;
  wire [NCH-1:0] udf_ev;
  integer k;
  integer p;

  // ==========================================================
  // input synchronisers; only stage two feeds logic
  always @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sync1_reg <= {NIN{1'b0}};
      sync2_reg <= {NIN{1'b0}};
      clk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {PORT_CLK_I, SLOT_MARK_I, WORD_QUAL_I, PORT_DATA_I};
      sync2_reg <= sync1_reg;
      clk_d_reg <= clk_s;
    end
  end

  assign clk_s = sync2_reg[NIN-1];
  assign mark_s = sync2_reg[NIN-2];
  assign qual_s = sync2_reg[NIN-3 -: `TSP_NPORT];
  assign data_s = sync2_reg[`TSP_NPORT*`TSP_DW-1:0];
  // one shared clock for all ports; each active edge is one slot [RULE_01]
  assign rise = clk_s & ~clk_d_reg;
  assign fall = ~clk_s & clk_d_reg;
  assign edge_act = rise | (fall & DDR_MODE_I); // [RULE_21]

  // slot count limits differ per mode; bad values stop the counter [RULE_24]
  assign cfg_ok = (SLOT_COUNT_I >= `TSP_SLOT_MIN) &&
    (DDR_MODE_I ? (~SLOT_COUNT_I[0] && SLOT_COUNT_I <= `TSP_SLOT_MAX_DDR)
                : (SLOT_COUNT_I <= `TSP_SLOT_MAX_SDR));

  // ==========================================================
  // slot counter: marker on a rising edge restarts at slot 1
  always @* begin
    slot_next = slot_reg;
    if (!cfg_ok) begin
      slot_next = `TSP_SLOT_NONE;
    end else if (rise && mark_s) begin
      slot_next = `TSP_SLOT_FIRST; // [RULE_23] [RULE_25]
    end else if (edge_act && slot_reg != `TSP_SLOT_NONE) begin
      if (slot_reg >= SLOT_COUNT_I) begin
        slot_next = `TSP_SLOT_FIRST; // free-running rollover [RULE_25]
      end else begin
        slot_next = slot_reg + `TSP_SLOT_FIRST; // [RULE_17] [RULE_22]
      end
    end
  end

  // accept for the slot being entered, gathered from all channels
  always @* begin
    accept_next = {`TSP_NPORT{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      for (p = 0; p < `TSP_NPORT; p = p + 1) begin
        accept_next[p] = accept_next[p] | acc_vote[k*`TSP_NPORT+p];
      end
    end
  end

  // ==========================================================
  // slot state, accept outputs, config error, interrupt
  always @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      slot_reg <= `TSP_SLOT_NONE;
      FIFO_ACCEPT_O <= {`TSP_NPORT{1'b0}};
      CFG_ERR_O <= 1'b0;
      IRQ_N_O <= 1'b1;
    end else begin
      slot_reg <= slot_next;
      if (edge_act) begin
        FIFO_ACCEPT_O <= accept_next; // held for the whole slot [RULE_10]
      end
      CFG_ERR_O <= ~cfg_ok;
      IRQ_N_O <= ~|(UDF_FLAGS_O & UDF_IRQ_EN_I); // active low [RULE_13]
    end
  end

  // ==========================================================
  // clear-on-read flags; a new event in the read cycle survives
  always @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      OVF_FLAGS_O <= {NCH{1'b0}};
      UDF_FLAGS_O <= {NCH{1'b0}};
    end else begin
      OVF_FLAGS_O <= (OVF_READ_I ? {NCH{1'b0}} : OVF_FLAGS_O) | ovf_ev; // [RULE_12]
      UDF_FLAGS_O <= (UDF_READ_I ? {NCH{1'b0}} : UDF_FLAGS_O) | udf_ev; // [RULE_14]
    end
  end

  // ==========================================================
  // one fifo per channel
  genvar c;
  genvar q;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      reg [`TSP_DW-1:0] mem [0:`TSP_DEPTH-1];
      reg [`TSP_AW-1:0] wp_reg;
      reg [`TSP_AW-1:0] rp_reg;
      reg [`TSP_CW-1:0] cnt_reg;
      reg run_reg;
      wire [`TSP_PW-1:0] ch_port;
      wire [`TSP_SW-1:0] ch_slot;
      wire [`TSP_DW-1:0] word;
      wire [`TSP_DW-1:0] head;
      wire [`TSP_OW-1:0] fmt;
      wire muted;
      wire hit;
      wire wr;
      wire full;
      wire rd;
      wire buf_ready;
      integer m;

      assign ch_port = CH_PORT_I[c*`TSP_PW +: `TSP_PW];
      assign ch_slot = CH_SLOT_I[c*`TSP_SW +: `TSP_SW];
      assign muted = (ch_slot == `TSP_SLOT_NONE); // [RULE_26]
      // only an assigned slot lands anywhere [RULE_03] [RULE_19]
      assign hit = edge_act && !muted && (slot_next == ch_slot);
      assign word = data_s[ch_port*`TSP_DW +: `TSP_DW]; // [RULE_04]
      assign full = (cnt_reg == `TSP_CNT_FULL);
      // writing ignores accept and the half mark; only full blocks it [RULE_08] [RULE_11]
      assign wr = hit && qual_s[ch_port] && !full;
      assign ovf_ev[c] = hit && qual_s[ch_port] && full; // drop the word [RULE_27]
      // q in upper half, i in lower; offset bit shared by both [RULE_05] [RULE_06] [RULE_07]
      assign head = mem[rp_reg]; // oldest stored word, not the live port word [RULE_09]
      assign fmt = CH_OFS_EN_I[c] ?
        {head[`TSP_DW-1:`TSP_HALF_W], CH_OFS_I[c], head[`TSP_HALF_W-1:0], CH_OFS_I[c]} :
        {2'b00, head};
      // reads run only after reaching half-full [RULE_15]
      assign rd = run_reg && (cnt_reg != `TSP_CNT_ZERO) && buf_ready;
      // underflow only once running, on a read with nothing held [RULE_16] [RULE_13]
      assign udf_ev[c] = run_reg && (cnt_reg == `TSP_CNT_ZERO) && !RD_VALID_O[c] && RD_READY_I[c];
      // vote for accept: own slot, below 8 words [RULE_10]
      for (q = 0; q < `TSP_NPORT; q = q + 1) begin : g_vote
        assign acc_vote[c*`TSP_NPORT+q] = !muted && (ch_port == q) &&
          (slot_next == ch_slot) && (cnt_reg < `TSP_CNT_HALF);
      end

      // storage and pointers; contents zero after reset [RULE_09]
      always @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          for (m = 0; m < `TSP_DEPTH; m = m + 1) begin
            mem[m] <= {`TSP_DW{1'b0}};
          end
          wp_reg <= `TSP_PTR_ZERO;
          rp_reg <= `TSP_PTR_ZERO;
          cnt_reg <= `TSP_CNT_ZERO;
          run_reg <= 1'b0;
        end else begin
          if (wr) begin
            mem[wp_reg] <= word;
            wp_reg <= wp_reg + `TSP_PTR_ONE;
          end
          if (rd) begin
            rp_reg <= rp_reg + `TSP_PTR_ONE;
          end
          if (wr && !rd) begin
            cnt_reg <= cnt_reg + `TSP_CNT_ONE;
          end else if (rd && !wr) begin
            cnt_reg <= cnt_reg - `TSP_CNT_ONE;
          end
          if (udf_ev[c]) begin
            run_reg <= 1'b0; // hold reads until refilled [RULE_15]
          end else if (cnt_reg >= `TSP_CNT_HALF) begin
            run_reg <= 1'b1;
          end
        end
      end

      // two-entry buffer toward the resampler absorbs its stalls
      tsp_buf2 #(
        .W(`TSP_OW)
      ) u_buf (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .in_valid_i(rd),
        .in_ready_o(buf_ready),
        .in_data_i(fmt),
        .out_valid_o(RD_VALID_O[c]),
        .out_ready_i(RD_READY_I[c]),
        .out_data_o(RD_DATA_O[c*`TSP_OW +: `TSP_OW])
      );
    end
  endgenerate
endmodule // tsp_fifo_top

`default_nettype wire

// ### src/tsp_fifo_consts.vh
// ============================================================
// constants for the tdm symbol port and channel fifos
// assumes inclusion by bare name from the design files
`ifndef TSP_FIFO_CONSTS_VH
`define TSP_FIFO_CONSTS_VH

// ============================================================
// port geometry
`define TSP_NPORT 4
`define TSP_PW 2
`define TSP_DW 10
`define TSP_HALF_W 5
`define TSP_OW 12
`define TSP_SW 6

// ============================================================
// slot counter limits
`define TSP_SLOT_NONE 6'h00
`define TSP_SLOT_FIRST 6'h01
`define TSP_SLOT_MIN 6'h02
`define TSP_SLOT_MAX_DDR 6'h20
`define TSP_SLOT_MAX_SDR 6'h10

// ============================================================
// fifo sizing
`define TSP_DEPTH 16
`define TSP_AW 4
`define TSP_CW 5
`define TSP_CNT_ZERO 5'h00
`define TSP_CNT_ONE 5'h01
`define TSP_CNT_FULL 5'h10
`define TSP_CNT_HALF 5'h08
`define TSP_PTR_ONE 4'h1
`define TSP_PTR_ZERO 4'h0

`endif

// ### tb/tsp_fifo_chk.sv
// checker for the symbol port top, sees top ports only
// assumes bind onto tsp_fifo_top, NCH of at least 4
`timescale 1ns/1ns
`default_nettype none
// =====
// port watch and assertions
module tsp_chk #(parameter NCH = 4) (
  input wire logic SYS_CLK_I, input wire logic SYS_RST_I,
  input wire logic DDR_MODE_I, input wire logic [5:0] SLOT_COUNT_I, input wire logic CFG_ERR_O,
  input wire logic [NCH*6-1:0] CH_SLOT_I, input wire logic [NCH-1:0] CH_OFS_EN_I,
  input wire logic [NCH-1:0] CH_OFS_I, input wire logic [NCH-1:0] RD_VALID_O,
  input wire logic [NCH-1:0] RD_READY_I, input wire logic [NCH*12-1:0] RD_DATA_O,
  input wire logic [NCH-1:0] OVF_FLAGS_O, input wire logic [NCH-1:0] UDF_FLAGS_O,
  input wire logic UDF_READ_I, input wire logic [NCH-1:0] UDF_IRQ_EN_I, input wire logic IRQ_N_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // count legal per mode; zero and one never legal
  wire logic bad = SLOT_COUNT_I < 6'h02 ||
    (DDR_MODE_I ? (SLOT_COUNT_I > 6'h20 || SLOT_COUNT_I[0]) : SLOT_COUNT_I > 6'h10);
  chk_cfg_limit: assert property ($stable(SLOT_COUNT_I) && $stable(DDR_MODE_I) |=> CFG_ERR_O == $past(bad))
    else $error("slot count flag wrong");
  chk_irq_follow: assert property (IRQ_N_O == !(|$past(UDF_FLAGS_O & UDF_IRQ_EN_I)))
    else $error("interrupt level wrong");
  chk_udf_cause: assert property ((UDF_FLAGS_O & ~$past(UDF_FLAGS_O) & ~$past(RD_READY_I & ~RD_VALID_O)) == '0)
    else $error("underflow without empty read");
  chk_udf_clear: assert property (UDF_READ_I && RD_READY_I == '0 |=> UDF_FLAGS_O == '0)
    else $error("underflow flags not cleared");
  chk_valid_hold: assert property (($past(RD_VALID_O & ~RD_READY_I) & ~RD_VALID_O) == '0)
    else $error("word dropped before taken");
  chk_data_hold: assert property (RD_VALID_O[0] && !RD_READY_I[0] |=> $stable(RD_DATA_O[11:0]))
    else $error("word changed before taken");
  // offset bit repeats beside both halves
  chk_ofs_form: assert property (RD_VALID_O[2] && CH_OFS_EN_I[2] |-> RD_DATA_O[30] == CH_OFS_I[2] && RD_DATA_O[24] == CH_OFS_I[2])
    else $error("offset form wrong");
  chk_mute_quiet: assert property (CH_SLOT_I[23:18] == 6'h00 |-> !RD_VALID_O[3])
    else $error("muted channel has data");
  cover property (RD_VALID_O[0] && RD_READY_I[0]);
  cover property ($rose(OVF_FLAGS_O[0]));
  cover property ($fell(IRQ_N_O));
endmodule // tsp_chk
bind tsp_fifo_top tsp_chk #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// ### tb/tsp_src.sv
// upstream symbol source: free port clock, marker, words
// assumes the bench sets mode, slot count and qualifier mask
`timescale 1ns/1ns
`default_nettype none
// =====
// source model
module tsp_src (
  input wire logic ddr_i,
  input wire logic [5:0] n_i,
  input wire logic [3:0] qen_i,
  output logic pclk_o,
  output logic mark_o,
  output logic [39:0] data_o,
  output logic [3:0] qual_o
);
  int s = 1; // slot of the next active edge
  // clock never stops; inputs move midway so they stand 200ns each side
  initial begin
    pclk_o = 1'b0; mark_o = 1'b0; data_o = '0; qual_o = 4'h0;
    #37;
    forever begin
      #200 pclk_o = ~pclk_o;
      #200;
      if (ddr_i && pclk_o && s == 1) s = 2; // slot 1 must meet a rising edge
      if (!pclk_o) mark_o = (s == 1); // high one full period, seen by one rising edge
      if (ddr_i || !pclk_o) begin
        for (int p = 0; p < 4; p++) data_o[p*10+:10] = {p[1:0], 3'b101, s[4:0]};
        qual_o = qen_i;
        s = (s >= n_i) ? 1 : s + 1; // one count for all ports
      end
    end
  end
endmodule // tsp_src
`default_nettype wire

// ### tb/tsp_fifo_top_bench.sv
// bench for the symbol port top with a source model
// assumes tsp_src and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tsp_fifo_top_bench;
  localparam int NCH = 4;
  logic SYS_CLK_I = 1'b0, SYS_RST_I = 1'b1, DDR_MODE_I = 1'b0, OVF_READ_I = 1'b0, UDF_READ_I = 1'b0;
  logic PORT_CLK_I, SLOT_MARK_I, CFG_ERR_O, IRQ_N_O, seen;
  logic [39:0] PORT_DATA_I;
  logic [3:0] WORD_QUAL_I, FIFO_ACCEPT_O, qen = 4'h0;
  logic [5:0] SLOT_COUNT_I = 6'h04;
  logic [7:0] CH_PORT_I = 8'h34; // ch0 p0, ch1 p1, ch2 p3, ch3 p0
  logic [23:0] CH_SLOT_I = {6'h00, 6'h02, 6'h03, 6'h01}; // ch3 muted
  logic [3:0] CH_OFS_EN_I = 4'h4, CH_OFS_I = 4'h4, UDF_IRQ_EN_I = 4'h1, RD_READY_I = 4'h0;
  logic [3:0] RD_VALID_O, OVF_FLAGS_O, UDF_FLAGS_O;
  logic [47:0] RD_DATA_O;
  // {ddr, count, flag}; count 2 is the single-stream setting
  logic [7:0] rows [8] = '{8'h01, 8'h03, 8'h04, 8'h20, 8'h23, 8'h87, 8'hc0, 8'hc5};
  int num_errors = 0, total_checks = 0, cyc = 0, taken = 0, t;
  tsp_src u_src (.ddr_i(DDR_MODE_I), .n_i(SLOT_COUNT_I), .qen_i(qen), .pclk_o(PORT_CLK_I),
    .mark_o(SLOT_MARK_I), .data_o(PORT_DATA_I), .qual_o(WORD_QUAL_I));
  tsp_fifo_top #(.NCH(NCH)) uut (.*);
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  // hang guard well above the few thousand cycles needed
  always @(posedge SYS_CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin num_errors++; summarize(); end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin num_errors++; $display("[ERR] %0t seen %h expected %h", $time, got, exp); end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n); repeat (n) @(posedge SYS_CLK_I); endtask
  // =====
  // main sequence
  initial begin
    tick(5); @(negedge SYS_CLK_I);
    check({FIFO_ACCEPT_O, RD_VALID_O, OVF_FLAGS_O, UDF_FLAGS_O, 3'h0, IRQ_N_O}, 20'h0_0001);
    @(posedge SYS_CLK_I); SYS_RST_I <= 1'b0;
    foreach (rows[i]) begin
      @(posedge SYS_CLK_I); {DDR_MODE_I, SLOT_COUNT_I} <= rows[i][7:1];
      tick(3); @(negedge SYS_CLK_I); check(CFG_ERR_O, rows[i][0]);
    end
    @(posedge SYS_CLK_I); {DDR_MODE_I, SLOT_COUNT_I} <= 7'h04; qen <= 4'hb; // port 2 idle
    t = 0; while (FIFO_ACCEPT_O[0] !== 1'b1 && t < 300) begin tick(1); t++; end
    check(FIFO_ACCEPT_O[0], 1'b1);
    tick(400); seen = 1'b0;
    repeat (64) begin tick(1); seen |= FIFO_ACCEPT_O[0]; end
    check(seen, 1'b0);
    tick(600); @(negedge SYS_CLK_I);
    check(OVF_FLAGS_O, 4'h7);
    check(RD_VALID_O, 4'h7);
    check(RD_DATA_O[35:24], 12'hec5);
    check(RD_DATA_O[23:12], 12'h1a3);
    @(posedge SYS_CLK_I); qen <= 4'h0; tick(64);
    @(posedge SYS_CLK_I); OVF_READ_I <= 1'b1; @(posedge SYS_CLK_I); OVF_READ_I <= 1'b0;
    @(negedge SYS_CLK_I); check(OVF_FLAGS_O, 4'h0);
    // drain channel 0 past empty: stored words then underflow
    @(posedge SYS_CLK_I); RD_READY_I <= 4'h1;
    // look between edges; each following rising edge takes the word seen
    repeat (24) begin
      @(negedge SYS_CLK_I);
      if (RD_VALID_O[0] === 1'b1) begin taken++; check(RD_DATA_O[11:0], 12'h0a1); end
      @(posedge SYS_CLK_I);
    end
    RD_READY_I <= 4'h0; UDF_READ_I <= 1'b1;
    check(taken >= 16 && taken <= 18, 1'b1);
    check({UDF_FLAGS_O, 3'h0, IRQ_N_O}, 8'h10);
    @(posedge SYS_CLK_I); UDF_READ_I <= 1'b0; tick(1); @(negedge SYS_CLK_I);
    check({UDF_FLAGS_O, 3'h0, IRQ_N_O}, 8'h01);
    // refill: no word and no underflow until eight words are in
    @(posedge SYS_CLK_I); RD_READY_I <= 4'h1; qen <= 4'h1; t = 0; seen = 1'b0;
    while (RD_VALID_O[0] !== 1'b1 && t < 500) begin @(posedge SYS_CLK_I); t++; seen |= UDF_FLAGS_O[0]; end
    check(t >= 224 && t < 500, 1'b1);
    check(seen, 1'b0);
    // mid-run reset into ddr, count 4: both edges fill, slot 1 on the rising edge
    @(posedge SYS_CLK_I); SYS_RST_I <= 1'b1; {DDR_MODE_I, SLOT_COUNT_I} <= 7'h44; RD_READY_I <= 4'h0;
    tick(4); @(negedge SYS_CLK_I);
    check({FIFO_ACCEPT_O, RD_VALID_O, OVF_FLAGS_O, UDF_FLAGS_O, 3'h0, IRQ_N_O}, 20'h0_0001);
    @(posedge SYS_CLK_I); SYS_RST_I <= 1'b0; t = 0;
    while (RD_VALID_O[0] !== 1'b1 && t < 500) begin @(posedge SYS_CLK_I); t++; end
    check(t >= 112 && t < 160, 1'b1);
    @(negedge SYS_CLK_I); check(RD_DATA_O[11:0], 12'h0a1);
    summarize();
  end
endmodule // tsp_fifo_top_bench
`default_nettype wire
